// ==== spi_nvram_access_and_protect.v ====
// SPI command logic for a 32K x 8 nonvolatile SRAM: protection, reads, writes, specials
`timescale 1ns/1ps
`default_nettype none
`include "nvram_spi_defines.vh"

module spi_nvram_access_and_protect (
    input wire i_clk,
    input wire i_reset,
    input wire i_cs_n,
    input wire i_sck,
    input wire i_si,
    input wire i_wp_n,
    output reg o_so,
    output reg o_so_oe_n,
    output reg o_rd_req,
    output reg [14:0] o_rd_addr,
    input wire i_rd_valid,
    input wire [7:0] i_rd_data,
    output wire o_wr_valid,
    input wire i_wr_ready,
    output wire [14:0] o_wr_addr,
    output wire [7:0] o_wr_data,
    input wire i_nv_busy,
    output reg o_save_req,
    output reg o_recall_req,
    output reg o_ready_busy,
    output reg o_hardware_save_busy_pin_n,
    output reg o_write_latch,
    output reg o_protect_pin_enable,
    output reg o_block_protect_hi,
    output reg o_block_protect_lo,
    output reg o_power_loss_save
);
    localparam [2:0] S_CMD = 3'h0;
    localparam [2:0] S_ADDR = 3'h1;
    localparam [2:0] S_DUMMY = 3'h2;
    localparam [2:0] S_RDATA = 3'h3;
    localparam [2:0] S_WDATA = 3'h4;
    localparam [2:0] S_STAT = 3'h5;
    localparam [2:0] S_IGN = 3'h6;

    localparam [2:0] A_NONE = 3'h0;
    localparam [2:0] A_SET_LATCH = 3'h1;
    localparam [2:0] A_WRDI = 3'h2;
    localparam [2:0] A_SAVE = 3'h3;
    localparam [2:0] A_RECALL = 3'h4;
    localparam [2:0] A_AUTO_ON = 3'h5;
    localparam [2:0] A_AUTO_OFF = 3'h6;
    localparam [2:0] A_CLR = 3'h7;

    localparam [`TSS_CNT_W-1:0] TSS_CYC = `T_SS_CYC;

    // Next address; 15 bits so the top address rolls to zero
    function [14:0] addr_inc;
        input [14:0] a;
        begin
            addr_inc = (a == `ADDR_TOP) ? `ADDR_ZERO : a + 15'h0001;
        end
    endfunction

    function is_protected;
        input [14:0] a;
        input hi;
        input lo;
        begin
            case ({hi, lo})
                2'b01: is_protected = (a >= `QUARTER_BASE);
                2'b10: is_protected = (a >= `HALF_BASE);
                2'b11: is_protected = 1'b1;
                default: is_protected = 1'b0;
            endcase
        end
    endfunction

    // Pin synchronisers: stage 1 feeds only stage 2
    reg cs_s1_q, cs_s2_q, cs_s3_q;
    reg sck_s1_q, sck_s2_q, sck_s3_q;
    reg si_s1_q, si_s2_q;
    reg wp_s1_q, wp_s2_q;

    always @(posedge i_clk) begin
        if (i_reset) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
            sck_s1_q <= 1'b0;
            sck_s2_q <= 1'b0;
            sck_s3_q <= 1'b0;
            si_s1_q <= 1'b0;
            si_s2_q <= 1'b0;
            wp_s1_q <= 1'b1;
            wp_s2_q <= 1'b1;
        end else begin
            cs_s1_q <= i_cs_n;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
            sck_s1_q <= i_sck;
            sck_s2_q <= sck_s1_q;
            sck_s3_q <= sck_s2_q;
            si_s1_q <= i_si;
            si_s2_q <= si_s1_q;
            wp_s1_q <= i_wp_n;
            wp_s2_q <= wp_s1_q;
        end
    end

    wire sel = ~cs_s2_q;
    wire cs_rise = cs_s2_q & ~cs_s3_q;
    wire sck_rise = sel & sck_s2_q & ~sck_s3_q;
    wire sck_fall = sel & ~sck_s2_q & sck_s3_q;

    reg [2:0] state_q;
    reg [2:0] act_q;
    reg [7:0] op_q;
    reg [2:0] bit_q;
    reg [6:0] sh_in_q;
    reg addr_lo_q;
    reg [14:0] addr_q;
    reg stat_ok_q;
    reg [7:0] rd_q;
    reg [7:0] so_sh_q;
    reg [2:0] obit_q;
    reg pend_v_q;
    reg [22:0] pend_q;
    reg [`TSS_CNT_W-1:0] tss_q;

    wire [7:0] byte_in = {sh_in_q, si_s2_q};
    wire byte_done = sck_rise & (bit_q == 3'h7);
    // busy covers nonvolatile cycles and the auto-save settle time
    wire busy = i_nv_busy | (tss_q != {`TSS_CNT_W{1'b0}});
    wire buf_ready;
    wire [22:0] buf_out;

    wr_buf2 #(
        .WIDTH(`WBUF_W)
    ) u_wbuf (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_in_valid(pend_v_q),
        .o_in_ready(buf_ready),
        .i_in_data(pend_q),
        .o_out_valid(o_wr_valid),
        .i_out_ready(i_wr_ready),
        .o_out_data(buf_out)
    );

    assign o_wr_addr = buf_out[22:8];
    assign o_wr_data = buf_out[7:0];

    always @(posedge i_clk) begin
        if (i_reset) begin
            state_q <= S_CMD;
            act_q <= A_NONE;
            op_q <= 8'h00;
            bit_q <= 3'h0;
            sh_in_q <= 7'h00;
            addr_lo_q <= 1'b0;
            addr_q <= `ADDR_ZERO;
            stat_ok_q <= 1'b0;
            rd_q <= 8'h00;
            so_sh_q <= 8'h00;
            obit_q <= 3'h0;
            pend_v_q <= 1'b0;
            pend_q <= 23'h000000;
            tss_q <= {`TSS_CNT_W{1'b0}};
            o_so <= 1'b0;
            o_so_oe_n <= 1'b1;
            o_rd_req <= 1'b0;
            o_rd_addr <= `ADDR_ZERO;
            o_save_req <= 1'b0;
            o_recall_req <= 1'b0;
            o_ready_busy <= 1'b0;
            o_hardware_save_busy_pin_n <= 1'b1;
            o_write_latch <= `RST_WRITE_LATCH;
            o_protect_pin_enable <= `RST_PPE;
            o_block_protect_hi <= `RST_BP;
            o_block_protect_lo <= `RST_BP;
            o_power_loss_save <= `RST_AUTO_SAVE;
        end else begin
            o_rd_req <= 1'b0;
            o_save_req <= 1'b0;
            o_recall_req <= 1'b0;
            o_ready_busy <= busy;
            o_hardware_save_busy_pin_n <= ~i_nv_busy;
            if (tss_q != {`TSS_CNT_W{1'b0}}) begin
                tss_q <= tss_q - {{(`TSS_CNT_W-1){1'b0}}, 1'b1};
            end
            if (i_rd_valid) begin
                rd_q <= i_rd_data;
            end
            // Held word waits here, so a stalled drain stops no byte from landing
            if (pend_v_q && buf_ready) begin
                pend_v_q <= 1'b0;
            end

            if (sck_rise) begin
                sh_in_q <= byte_in[6:0];
                bit_q <= bit_q + 3'h1;
            end

            if (byte_done) begin
                case (state_q)
                    S_CMD: begin
                        op_q <= byte_in;
                        addr_lo_q <= 1'b0;
                        state_q <= S_IGN;
                        case (byte_in)
                            `OP_READ, `OP_FAST_READ: begin
                                if (!busy) begin
                                    state_q <= S_ADDR;
                                end
                            end
                            `OP_WRITE: begin
                                if (!busy && o_write_latch) begin
                                    state_q <= S_ADDR;
                                    act_q <= A_CLR;
                                end
                            end
                            `OP_WRSR: begin
                                if (o_write_latch) begin
                                    state_q <= S_STAT;
                                    act_q <= A_CLR;
                                    stat_ok_q <= ~(o_protect_pin_enable & ~wp_s2_q);
                                end
                            end
                            `OP_SET_WRITE_LATCH_CMD: act_q <= A_SET_LATCH;
                            `OP_WRDI: act_q <= A_WRDI;
                            // specials only with the latch set
                            `OP_SAVE: act_q <= o_write_latch ? A_SAVE : A_NONE;
                            `OP_RECALL: act_q <= o_write_latch ? A_RECALL : A_NONE;
                            `OP_AUTO_ON: act_q <= o_write_latch ? A_AUTO_ON : A_NONE;
                            `OP_AUTO_OFF: act_q <= o_write_latch ? A_AUTO_OFF : A_NONE;
                            default: act_q <= A_NONE;
                        endcase
                    end
                    S_ADDR: begin
                        addr_lo_q <= 1'b1;
                        if (!addr_lo_q) begin
                            addr_q[14:8] <= byte_in[6:0];
                        end else begin
                            addr_q[7:0] <= byte_in;
                            if (op_q == `OP_WRITE) begin
                                state_q <= S_WDATA;
                            end else if (op_q == `OP_FAST_READ) begin
                                state_q <= S_DUMMY;
                            end else begin
                                state_q <= S_RDATA;
                                o_rd_req <= 1'b1;
                                o_rd_addr <= {addr_q[14:8], byte_in};
                            end
                        end
                    end
                    S_DUMMY: begin
                        state_q <= S_RDATA;
                        o_rd_req <= 1'b1;
                        o_rd_addr <= addr_q;
                    end
                    S_WDATA: begin
                        // protected bytes dropped, address still advances
                        if (!is_protected(addr_q, o_block_protect_hi, o_block_protect_lo)) begin
                            pend_v_q <= 1'b1;
                            pend_q <= {addr_q, byte_in};
                        end
                        addr_q <= addr_inc(addr_q);
                    end
                    S_STAT: begin
                        state_q <= S_IGN;
                        if (stat_ok_q) begin
                            o_protect_pin_enable <= byte_in[`SR_PPE_BIT];
                            o_block_protect_hi <= byte_in[`SR_BP_HI_BIT];
                            o_block_protect_lo <= byte_in[`SR_BP_LO_BIT];
                        end
                    end
                    default: state_q <= state_q;
                endcase
            end

            // output on falling edges, MSB first; SI is ignored here
            if (sck_fall && state_q == S_RDATA) begin
                obit_q <= obit_q + 3'h1;
                o_so_oe_n <= 1'b0;
                if (obit_q == 3'h0) begin
                    o_so <= rd_q[7];
                    so_sh_q <= {rd_q[6:0], 1'b0};
                    // prefetch the next address with wrap
                    addr_q <= addr_inc(addr_q);
                    o_rd_addr <= addr_inc(addr_q);
                    o_rd_req <= 1'b1;
                end else begin
                    o_so <= so_sh_q[7];
                    so_sh_q <= {so_sh_q[6:0], 1'b0};
                end
            end

            if (!sel) begin
                state_q <= S_CMD;
                bit_q <= 3'h0;
                obit_q <= 3'h0;
                o_so_oe_n <= 1'b1;
            end

            if (cs_rise) begin
                act_q <= A_NONE;
                case (act_q)
                    A_SET_LATCH: o_write_latch <= 1'b1;
                    A_WRDI: o_write_latch <= 1'b0;
                    A_SAVE: begin
                        o_save_req <= 1'b1;
                        o_write_latch <= 1'b0;
                    end
                    A_RECALL: begin
                        o_recall_req <= 1'b1;
                        o_write_latch <= 1'b0;
                    end
                    A_AUTO_ON: begin
                        o_power_loss_save <= 1'b1;
                        tss_q <= TSS_CYC;
                        o_write_latch <= 1'b0;
                    end
                    A_AUTO_OFF: begin
                        o_power_loss_save <= 1'b0;
                        tss_q <= TSS_CYC;
                        o_write_latch <= 1'b0;
                    end
                    // latch cleared when the sequence ends
                    A_CLR: o_write_latch <= 1'b0;
                    default: o_write_latch <= o_write_latch;
                endcase
            end
        end
    end
endmodule // spi_nvram_access_and_protect

`default_nettype wire

// ==== nvram_spi_defines.vh ====
// Constants for the serial nonvolatile SRAM command logic
`ifndef NVRAM_SPI_DEFINES_VH
`define NVRAM_SPI_DEFINES_VH

// Instruction codes
`define OP_WRSR 8'h01
`define OP_WRITE 8'h02
`define OP_READ 8'h03
`define OP_WRDI 8'h04
`define OP_SET_WRITE_LATCH_CMD 8'h06
`define OP_FAST_READ 8'h0B
`define OP_SAVE 8'h3C
`define OP_RECALL 8'h60
`define OP_AUTO_ON 8'h59
`define OP_AUTO_OFF 8'h19

// Array geometry
`define ADDR_W 15
`define DATA_W 8
`define WBUF_W 23
`define ADDR_TOP 15'h7FFF
`define ADDR_ZERO 15'h0000
`define QUARTER_BASE 15'h6000
`define HALF_BASE 15'h4000

// Status register field positions for a status write
`define SR_PPE_BIT 7
`define SR_BP_HI_BIT 3
`define SR_BP_LO_BIT 2

// Reset values
`define RST_WRITE_LATCH 1'b0
`define RST_PPE 1'b0
`define RST_BP 1'b0
`define RST_AUTO_SAVE 1'b1

// Timing
`define CLK_PERIOD_NS 40
`define T_SS_NS 1000
// Settle time of 1000 ns in 40 ns clocks, rounded up; sized to fit the timer
`define T_SS_CYC 8'h19
`define TSS_CNT_W 8

`endif

// ==== wr_buf2.v ====
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module wr_buf2 #(
    parameter WIDTH = 23
) (
    input wire i_clk,
    input wire i_reset,
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [WIDTH-1:0] i_in_data,
    output wire o_out_valid,
    input wire i_out_ready,
    output wire [WIDTH-1:0] o_out_data
);
    reg [WIDTH-1:0] e0_q;
    reg [WIDTH-1:0] e1_q;
    reg v0_q;
    reg v1_q;
    reg [WIDTH-1:0] e0_d;
    reg [WIDTH-1:0] e1_d;
    reg v0_d;
    reg v1_d;
    wire pop;
    wire push;

    assign pop = v0_q & i_out_ready;
    assign push = i_in_valid & ~v1_q;
    assign o_in_ready = ~v1_q;
    assign o_out_valid = v0_q;
    assign o_out_data = e0_q;

    always @* begin
        // Head always sits in entry 0, so a pop shifts entry 1 down
        v0_d = pop ? v1_q : v0_q;
        e0_d = pop ? e1_q : e0_q;
        v1_d = pop ? 1'b0 : v1_q;
        e1_d = e1_q;
        if (push) begin
            if (!v0_d) begin
                v0_d = 1'b1;
                e0_d = i_in_data;
            end else begin
                v1_d = 1'b1;
                e1_d = i_in_data;
            end
        end
    end

    always @(posedge i_clk) begin
        if (i_reset) begin
            v0_q <= 1'b0;
            v1_q <= 1'b0;
        end else begin
            v0_q <= v0_d;
            v1_q <= v1_d;
        end
        e0_q <= e0_d;
        e1_q <= e1_d;
    end
endmodule // wr_buf2

`default_nettype wire

// ==== nvram_chk_properties.sv ====
// Port checker for the SPI nvram command block
`timescale 1ns/1ps
`default_nettype none
module nvram_chk (
    input wire i_clk,
    input wire i_reset,
    input wire i_cs_n,
    input wire i_nv_busy,
    input wire i_wr_ready,
    input wire o_so_oe_n,
    input wire o_rd_req,
    input wire o_wr_valid,
    input wire [14:0] o_wr_addr,
    input wire [7:0] o_wr_data,
    input wire o_save_req,
    input wire o_recall_req,
    input wire o_ready_busy,
    input wire o_hardware_save_busy_pin_n,
    input wire o_write_latch,
    input wire o_power_loss_save
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // Six cycles covers the select synchroniser and the output register
    sequence s_cs_idle;
        i_cs_n [*6];
    endsequence
    sequence s_stall;
        o_wr_valid && !i_wr_ready;
    endsequence
    a_rd_pulse: assert property (o_rd_req |=> !o_rd_req)
        else $error("read request too long");
    a_save_pulse: assert property (o_save_req |=> !o_save_req)
        else $error("save request too long");
    a_word_held: assert property (s_stall |=>
        o_wr_valid && $stable(o_wr_addr) && $stable(o_wr_data))
        else $error("stalled word changed");
    a_so_idle: assert property (s_cs_idle |-> o_so_oe_n)
        else $error("serial out driven while deselected");
    a_busy_shown: assert property (i_nv_busy |=> o_ready_busy && !o_hardware_save_busy_pin_n)
        else $error("busy not shown");
    a_auto_busy: assert property ($changed(o_power_loss_save) |-> ##[0:3] o_ready_busy)
        else $error("no busy after auto save change");
    a_special_clr: assert property (o_save_req || o_recall_req |-> ##[0:2] !o_write_latch)
        else $error("latch kept after special");
    a_latch_set: assert property ($rose(o_write_latch) |-> $past(i_cs_n, 2))
        else $error("latch set inside frame");
endmodule // nvram_chk
bind spi_nvram_access_and_protect nvram_chk chk_u (.i_clk, .i_reset, .i_cs_n, .i_nv_busy,
    .i_wr_ready, .o_so_oe_n, .o_rd_req, .o_wr_valid, .o_wr_addr, .o_wr_data, .o_save_req,
    .o_recall_req, .o_ready_busy, .o_hardware_save_busy_pin_n, .o_write_latch,
    .o_power_loss_save);
`default_nettype wire

// ==== sram_model.sv ====
// SRAM array with a nonvolatile copy, facing the command block
`timescale 1ns/1ps
`default_nettype none
module sram_model #(
    parameter int BUSY_CYC = 1000
) (
    input wire i_clk,
    input wire i_stall,
    input wire i_rd_req,
    input wire [14:0] i_rd_addr,
    output logic o_rd_valid,
    output logic [7:0] o_rd_data,
    input wire i_wr_valid,
    output logic o_wr_ready,
    input wire [14:0] i_wr_addr,
    input wire [7:0] i_wr_data,
    input wire i_save_req,
    input wire i_recall_req,
    output logic o_nv_busy
);
    logic [7:0] mem [0:32767];
    logic [7:0] nv [0:32767];
    int cnt = 0;
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        nv = mem;
    end
    assign o_wr_ready = !i_stall;
    assign o_nv_busy = cnt != 0;
    always @(posedge i_clk) begin
        o_rd_valid <= i_rd_req;
        // Unqualified data flips so a late sample cannot pass by luck
        o_rd_data <= i_rd_req ? mem[i_rd_addr] : ~o_rd_data;
        if (i_wr_valid && !i_stall)
            mem[i_wr_addr] <= i_wr_data;
        // copies run behind a busy window
        if (cnt != 0)
            cnt <= cnt - 1;
        else if (i_save_req || i_recall_req)
            cnt <= BUSY_CYC;
        if (i_save_req)
            nv <= mem;
        if (i_recall_req)
            mem <= nv;
    end
endmodule // sram_model
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the SPI nvram command block
`timescale 1ns/1ps
`default_nettype none
`include "nvram_spi_defines.vh"
module testbench;
    logic i_clk = 1'b0, i_reset = 1'b1, i_cs_n = 1'b1, i_sck = 1'b0;
    logic i_si = 1'b0, i_wp_n = 1'b1, stall = 1'b0;
    wire o_so, o_so_oe_n, o_rd_req, i_rd_valid, o_wr_valid, i_wr_ready, i_nv_busy;
    wire o_save_req, o_recall_req, o_ready_busy, o_hardware_save_busy_pin_n;
    wire o_write_latch, o_protect_pin_enable, o_block_protect_hi, o_block_protect_lo;
    wire o_power_loss_save;
    wire [14:0] o_rd_addr, o_wr_addr;
    wire [7:0] i_rd_data, o_wr_data;
    wire [7:0] st = {2'b00, o_power_loss_save, o_protect_pin_enable,
        o_block_protect_hi, o_block_protect_lo, o_write_latch, o_ready_busy};
    int n_errors = 0, samples_checked = 0, saves = 0, nbit = 0;
    logic [1:0] cur_bp = 2'b00;
    bit cpol = 1'b0;
    logic [2:0] sck_h = 3'b000;
    logic [7:0] sh;
    logic [7:0] shadow [0:32767];
    logic [7:0] nv_shadow [0:32767];
    logic [7:0] exp_q [$];
    logic [7:0] sent [$];
    logic [15:0] ba [3] = '{16'h3FFF, 16'h5FFF, 16'h7FFF};

    always #20 i_clk = ~i_clk;
    spi_nvram_access_and_protect dut_u (.i_clk, .i_reset, .i_cs_n, .i_sck, .i_si, .i_wp_n,
        .o_so, .o_so_oe_n, .o_rd_req, .o_rd_addr, .i_rd_valid, .i_rd_data, .o_wr_valid,
        .i_wr_ready, .o_wr_addr, .o_wr_data, .i_nv_busy, .o_save_req, .o_recall_req,
        .o_ready_busy, .o_hardware_save_busy_pin_n, .o_write_latch, .o_protect_pin_enable,
        .o_block_protect_hi, .o_block_protect_lo, .o_power_loss_save);
    sram_model mem_u (.i_clk, .i_stall(stall), .i_rd_req(o_rd_req), .i_rd_addr(o_rd_addr),
        .o_rd_valid(i_rd_valid), .o_rd_data(i_rd_data), .i_wr_valid(o_wr_valid),
        .o_wr_ready(i_wr_ready), .i_wr_addr(o_wr_addr), .i_wr_data(o_wr_data),
        .i_save_req(o_save_req), .i_recall_req(o_recall_req), .o_nv_busy(i_nv_busy));

    task automatic cmp(string nm, logic [7:0] e, logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge i_clk);
    endtask
    // Slow serial clock; SI moves with the falling edge in either idle level
    task automatic sbyte(logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            i_sck <= 1'b0;
            i_si <= b[i];
            tick(4);
            i_sck <= 1'b1;
            tick(4);
        end
    endtask
    task automatic frame(logic [7:0] op, bit has_a, logic [15:0] a, int n, bit rnd,
        logic [7:0] d);
        logic [7:0] b;
        sent = {};
        i_cs_n <= 1'b0;
        tick(4);
        sbyte(op);
        if (has_a) begin
            sbyte(a[15:8]);
            sbyte(a[7:0]);
        end
        repeat (n) begin
            b = rnd ? 8'($urandom) : d;
            sent.push_back(b);
            sbyte(b);
        end
        i_sck <= cpol;
        tick(4);
        // select rises after the last bit
        i_cs_n <= 1'b1;
        tick(8);
    endtask
    task automatic special(logic [7:0] op);
        frame(op, 0, 16'h0000, 0, 0, 8'h00);
    endtask
    task automatic wrsr(logic [7:0] d);
        special(`OP_SET_WRITE_LATCH_CMD);
        frame(`OP_WRSR, 0, 16'h0000, 1, 0, d);
    endtask
    function automatic bit prot(logic [14:0] a);
        return cur_bp == 2'd3 || (cur_bp == 2'd2 && a >= 15'h4000)
            || (cur_bp == 2'd1 && a >= 15'h6000);
    endfunction
    task automatic do_write(logic [15:0] a, int n, bit ok);
        frame(`OP_WRITE, 1, a, n, 1, 8'h00);
        if (ok)
            foreach (sent[i])
                if (!prot(15'(a + i)))
                    shadow[15'(a + i)] = sent[i];
    endtask
    // Serial input during data is random: the device must ignore it
    task automatic do_read(logic [15:0] a, int n, bit fast, bit ex);
        for (int i = 0; i < n; i++)
            if (ex)
                exp_q.push_back(shadow[15'(a + i)]);
        frame(fast ? `OP_FAST_READ : `OP_READ, 1, a, n + fast, 1, 8'h00);
    endtask
    task automatic wait_ready();
        int k;
        for (k = 0; k < 3000 && o_ready_busy !== 1'b0; k++)
            tick(1);
        if (k == 3000) begin
            cmp("ready wait", 8'h00, 8'h01);
            end_sim();
        end
    endtask

    // Samples serial out three clocks after each rising serial clock
    always @(posedge i_clk) begin
        sck_h <= {sck_h[1:0], i_sck};
        stall <= ($urandom % 4) == 0;
        if (o_save_req === 1'b1)
            saves++;
        if (i_cs_n)
            nbit = 0;
        else if (sck_h[2:1] == 2'b01 && o_so_oe_n === 1'b0) begin
            sh = {sh[6:0], o_so};
            nbit++;
            if (nbit == 8) begin
                nbit = 0;
                cmp("read byte", exp_q.size() ? exp_q.pop_front() : 8'hXX, sh);
            end
        end
    end

    initial begin
        #3600000;
        cmp("watchdog", 8'h00, 8'h01);
        end_sim();
    end

    initial begin
        void'($urandom(93730));
        foreach (shadow[i]) shadow[i] = 8'h00;
        tick(16);
        i_reset <= 1'b0;
        tick(4);
        cmp("status", 8'h20, st);
        do_write(16'h0010, 2, 0);
        do_read(16'h0010, 2, 0, 1);
        special(`OP_SET_WRITE_LATCH_CMD);
        cmp("status", 8'h22, st);
        do_write(16'hFFFE, 4, 1);
        cmp("status", 8'h20, st);
        do_read(16'h7FFE, 4, 0, 1);
        do_read(16'hFFFF, 3, 1, 1);
        // Latched write and normal read with the serial clock idling high
        cpol = 1'b1;
        i_sck <= 1'b1;
        tick(4);
        special(`OP_SET_WRITE_LATCH_CMD);
        do_write(16'h2345, 3, 1);
        do_read(16'h2344, 5, 0, 1);
        cpol = 1'b0;
        i_sck <= 1'b0;
        tick(4);
        $display("test burst done");
        i_wp_n <= 1'b0;
        wrsr(8'h80);
        cmp("status", 8'h30, st & 8'hFD);
        wrsr(8'h8C);
        cmp("status", 8'h30, st & 8'hFD);
        i_wp_n <= 1'b1;
        fork
            wrsr(8'h8C);
            begin
                tick(160);
                i_wp_n <= 1'b0;
            end
        join
        cmp("status", 8'h3C, st & 8'hFD);
        i_wp_n <= 1'b1;
        wrsr(8'h00);
        cmp("status", 8'h20, st & 8'hFD);
        $display("test protect pin done");
        for (int m = 0; m < 4; m++) begin
            wrsr(8'(m * 4));
            cur_bp = 2'(m);
            foreach (ba[k]) begin
                special(`OP_SET_WRITE_LATCH_CMD);
                do_write(ba[k], 2, 1);
                do_read(ba[k], 2, 0, 1);
            end
        end
        wrsr(8'h00);
        cur_bp = 2'b00;
        $display("test block protect done");
        special(`OP_SAVE);
        cmp("saves", 8'h00, 8'(saves));
        special(`OP_SET_WRITE_LATCH_CMD);
        special(`OP_SAVE);
        nv_shadow = shadow;
        cmp("saves", 8'h01, 8'(saves));
        cmp("status", 8'h21, st);
        cmp("busy pin", 8'h00, {7'h00, o_hardware_save_busy_pin_n});
        do_read(16'h0010, 2, 0, 0);
        special(`OP_SET_WRITE_LATCH_CMD);
        do_write(16'h0010, 2, 0);
        wait_ready();
        do_read(16'h0010, 2, 0, 1);
        special(`OP_SET_WRITE_LATCH_CMD);
        do_write(16'h0010, 2, 1);
        special(`OP_SET_WRITE_LATCH_CMD);
        special(`OP_RECALL);
        shadow = nv_shadow;
        wait_ready();
        do_read(16'h0010, 2, 0, 1);
        $display("test save recall done");
        special(`OP_AUTO_OFF);
        cmp("status", 8'h20, st);
        special(`OP_SET_WRITE_LATCH_CMD);
        special(`OP_AUTO_OFF);
        cmp("status", 8'h01, st);
        wait_ready();
        special(`OP_SET_WRITE_LATCH_CMD);
        special(`OP_AUTO_ON);
        cmp("status", 8'h21, st);
        wait_ready();
        $display("test auto save done");
        tick(20);
        cmp("queue left", 8'h00, 8'(exp_q.size()));
        end_sim();
    end
endmodule // testbench
`default_nettype wire
